// file: pad_config_defines.svh
// Offsets, field positions and reset values of the pad setup registers
`ifndef PAD_CONFIG_DEFINES_SVH
`define PAD_CONFIG_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define PAD12_SETUP_OFS 12'h030
`define PAD13_SETUP_OFS 12'h034
`define PAD14_SETUP_OFS 12'h038
`define PAD15_SETUP_OFS 12'h03c
`define PAD16_SETUP_OFS 12'h040
`define PAD17_SETUP_OFS 12'h044
`define PAD18_SETUP_OFS 12'h048
`define PAD19_SETUP_OFS 12'h04c
`define PAD20_SETUP_OFS 12'h050
`define PAD21_SETUP_OFS 12'h054
`define PAD22_SETUP_OFS 12'h058
`define PAD23_SETUP_OFS 12'h05c
`define PAD24_SETUP_OFS 12'h060
`define PAD25_SETUP_OFS 12'h064

// ==========================================================
// Field positions
`define FUNC_LSB 0
`define SRC_LSB 3
`define DRV_OFF_BIT 5
`define PULL_LSB 6
`define STRENGTH_LSB 8
`define SLEW_BIT 10
`define RX_EN_BIT 11
`define HYST_BIT 12
`define SETUP_W 13
// Bit 2 and bits 31:13 hold nothing
`define SETUP_MASK 13'h1ffb

// ==========================================================
// Reset values, pads 12 to 25
`define PAD12_RST 13'h0120
`define PAD13_RST 13'h0120
`define PAD14_RST 13'h0128
`define PAD15_RST 13'h0128
`define PAD16_RST 13'h0920
`define PAD17_RST 13'h0128
`define PAD18_RST 13'h0120
`define PAD19_RST 13'h09a0
`define PAD20_RST 13'h09a0
`define PAD21_RST 13'h0120
`define PAD22_RST 13'h0120
`define PAD23_RST 13'h0120
`define PAD24_RST 13'h0120
`define PAD25_RST 13'h0120

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: pad_config_pkg.sv
// Types shared by the pad setup bank
package pad_config_pkg;
  typedef enum logic [1:0] {
    SRC_OWN = 2'h0,
    SRC_OTHER = 2'h1,
    SRC_FABRIC = 2'h2,
    SRC_SPARE = 2'h3
  } out_src_type;

  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_UP = 2'h1,
    PULL_DOWN = 2'h2,
    PULL_KEEP = 2'h3
  } pull_mode_type;
endpackage

// file: pad_setup_cell.sv
// One pad's setup register with byte-lane writes
`timescale 1ns/1ns
`include "pad_config_defines.svh"
module pad_setup_cell #(
  parameter logic [12:0] RESET_VAL = 13'h0120
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [12:0] wdata,
  input wire logic [1:0] wstrb,
  // Stored setup
  output logic [12:0] setup_r
);
  logic [12:0] lane_mask;

  always_comb begin
    lane_mask = {{5{wstrb[1]}}, {8{wstrb[0]}}} & `SETUP_MASK;
  end

  // Unused bits never store a one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_r <= RESET_VAL & `SETUP_MASK;
    end else if (wr_en) begin
      setup_r <= (setup_r & ~lane_mask) | (wdata & lane_mask);
    end
  end
endmodule

// file: pad_config_bank.sv
// Pad setup register bank for pads 12 to 25 with AXI4-Lite access
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "pad_config_defines.svh"

module pad_config_bank
  import pad_config_pkg::*;
#(
  parameter int NPADS = 14,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Output sources, same clock
  input wire logic [NPADS-1:0][3:0] func_dout,
  input wire logic [NPADS-1:0] other_dout,
  input wire logic [NPADS-1:0] other_oe_n,
  input wire logic [NPADS-1:0] fabric_dout,
  input wire logic [NPADS-1:0] fabric_oe_n,
  // Pin levels, asynchronous
  input wire logic [NPADS-1:0] pad_din,
  // Pad drive
  output logic [NPADS-1:0] pad_dout,
  output logic [NPADS-1:0] pad_oe_n,
  output logic [NPADS-1:0] rx_data,
  // Pad cell controls
  output logic [NPADS-1:0][1:0] pad_function_choice,
  output logic [NPADS-1:0][1:0] out_src_sel,
  output logic [NPADS-1:0] output_drive_off_n,
  output logic [NPADS-1:0][1:0] pull_mode,
  output logic [NPADS-1:0][1:0] drive_strength,
  output logic [NPADS-1:0] slew_rate_fast,
  output logic [NPADS-1:0] rx_enable,
  output logic [NPADS-1:0] hysteresis_on
);
  localparam int IDX_W = 4;
  localparam logic [12:0] RST_TAB [14] = '{
    `PAD12_RST, `PAD13_RST, `PAD14_RST, `PAD15_RST, `PAD16_RST,
    `PAD17_RST, `PAD18_RST, `PAD19_RST, `PAD20_RST, `PAD21_RST,
    `PAD22_RST, `PAD23_RST, `PAD24_RST, `PAD25_RST
  };
  localparam logic [ADDR_W-1:0] FIRST_OFS = ADDR_W'(`PAD12_SETUP_OFS);
  localparam logic [ADDR_W-1:0] LAST_OFS = ADDR_W'(`PAD25_SETUP_OFS);

  // ==========================================================
  // Write channel capture
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [12:0] w_data_r;
  logic [1:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_go;
  logic wr_hit;
  logic [IDX_W-1:0] wr_idx;
  logic [ADDR_W-1:0] wr_diff;

  assign awready = !aw_held_r;
  assign wready = !w_held_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  // Address and data may arrive in either order
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    wr_diff = aw_addr_r - FIRST_OFS;
    wr_idx = wr_diff[IDX_W+1:2];
    wr_hit = (aw_addr_r >= FIRST_OFS) && (aw_addr_r <= LAST_OFS) &&
             (aw_addr_r[1:0] == 2'h0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  // Only the low 13 data bits can ever be stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      w_data_r <= wdata[12:0];
      w_strb_r <= wstrb[1:0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Setup registers
  logic [12:0] cfg [NPADS];

  genvar g;
  generate
    for (g = 0; g < NPADS; g++) begin : g_pad
      // Stored value drives the pad controls from the next cycle on
      pad_setup_cell #(
        .RESET_VAL(RST_TAB[g])
      ) u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_go && wr_hit && (wr_idx == IDX_W'(g))),
        .wdata(w_data_r),
        .wstrb(w_strb_r),
        .setup_r(cfg[g])
      );
      assign pad_function_choice[g] = cfg[g][`FUNC_LSB+:2];
      assign out_src_sel[g] = cfg[g][`SRC_LSB+:2];
      assign output_drive_off_n[g] = cfg[g][`DRV_OFF_BIT];
      assign pull_mode[g] = cfg[g][`PULL_LSB+:2];
      assign drive_strength[g] = cfg[g][`STRENGTH_LSB+:2];
      assign slew_rate_fast[g] = cfg[g][`SLEW_BIT];
      assign rx_enable[g] = cfg[g][`RX_EN_BIT];
      assign hysteresis_on[g] = cfg[g][`HYST_BIT];
    end
  endgenerate

  // ==========================================================
  // Read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rd_hit;
  logic [IDX_W-1:0] rd_idx;
  logic [ADDR_W-1:0] rd_diff;

  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_comb begin
    rd_diff = araddr - FIRST_OFS;
    rd_idx = rd_diff[IDX_W+1:2];
    rd_hit = (araddr >= FIRST_OFS) && (araddr <= LAST_OFS) &&
             (araddr[1:0] == 2'h0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      // Upper bits are zero-filled; unmapped reads give zero data
      rdata_r <= rd_hit ? {19'h0, cfg[rd_idx]} : 32'h0000_0000;
      rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Output path selection
  logic [NPADS-1:0] sync1_r;
  logic [NPADS-1:0] sync2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_dout <= '0;
      pad_oe_n <= '1;
    end else begin
      for (int i = 0; i < NPADS; i++) begin
        case (out_src_type'(out_src_sel[i]))
          SRC_OWN: begin
            pad_dout[i] <= func_dout[i][pad_function_choice[i]];
            pad_oe_n[i] <= output_drive_off_n[i];
          end
          SRC_OTHER: begin
            pad_dout[i] <= other_dout[i];
            pad_oe_n[i] <= other_oe_n[i];
          end
          SRC_FABRIC: begin
            pad_dout[i] <= fabric_dout[i];
            pad_oe_n[i] <= fabric_oe_n[i];
          end
          default: begin
            // Spare code: keep the pin safe rather than guess a source
            pad_dout[i] <= 1'b0;
            pad_oe_n[i] <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Input receiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pad_din;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data <= '0;
    end else begin
      rx_data <= sync2_r & rx_enable;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_go;
    aw_held_r && w_held_r && !bvalid_r;
  endsequence

  sequence s_resp_up;
    bvalid && (bresp == (wr_hit ? `RESP_OKAY : `RESP_SLVERR));
  endsequence

  property p_wr_landed;
    s_wr_go ##0 (wr_hit && w_strb_r == 2'h3) |=>
      s_resp_up ##0 (cfg[$past(wr_idx)] == ($past(w_data_r) & `SETUP_MASK));
  endproperty
  a_wr_landed: assert property (p_wr_landed)
    else $error("written setup value not stored next cycle");

  property p_resp_holds;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_resp_holds: assert property (p_resp_holds)
    else $error("write response dropped before bready");

  property p_read_zero_bits;
    rvalid |-> rdata[31:13] == 19'h0 && rdata[2] == 1'b0;
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits)
    else $error("undefined setup bits read as one");

  property p_read_value;
    arvalid && arready && rd_hit |=> rvalid && rresp == `RESP_OKAY &&
      rdata[12:0] == $past(cfg[rd_idx]);
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("read data does not match stored setup");

  // Unmapped or misaligned reads answer an error with all-zero data
  property p_read_unmapped;
    arvalid && arready && !rd_hit |=> rvalid &&
      rresp == `RESP_SLVERR && rdata == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not refused with zero data");

  generate
    for (g = 0; g < NPADS; g++) begin : g_chk
      // Sampled reset guard: the release edge still launches reset values,
      // so the pad path cannot follow its sources across that edge
      property p_own_path;
        aresetn && out_src_sel[g] == SRC_OWN |=>
          pad_oe_n[g] == $past(output_drive_off_n[g]) &&
          pad_dout[g] == $past(func_dout[g][pad_function_choice[g]]);
      endproperty
      a_own_path: assert property (p_own_path)
        else $error("register control not driving pad");

      property p_other_fabric;
        (aresetn && out_src_sel[g] == SRC_OTHER |=>
           pad_dout[g] == $past(other_dout[g]) &&
           pad_oe_n[g] == $past(other_oe_n[g])) and
        (aresetn && out_src_sel[g] == SRC_FABRIC |=>
           pad_dout[g] == $past(fabric_dout[g]) &&
           pad_oe_n[g] == $past(fabric_oe_n[g]));
      endproperty
      a_other_fabric: assert property (p_other_fabric)
        else $error("selected output source not routed");

      property p_ctl_only_on_write;
        aresetn &&
        $changed({pull_mode[g], drive_strength[g], slew_rate_fast[g],
                  hysteresis_on[g]}) |->
          $past(wr_go && wr_hit && wr_idx == IDX_W'(g));
      endproperty
      a_ctl_only_on_write: assert property (p_ctl_only_on_write)
        else $error("pad control changed without a write");

      property p_rx_gate;
        !rx_enable[g] |=> !rx_data[g];
      endproperty
      a_rx_gate: assert property (p_rx_gate)
        else $error("receiver passed data while disabled");
    end
  endgenerate
endmodule

// file: pad_config_bank_test.sv
// Self-checking testbench for the pad setup register bank
`timescale 1ns/1ns
`include "pad_config_defines.svh"
module pad_config_bank_test import pad_config_pkg::*;;
  // ==========================================================
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [13:0][3:0] func_dout;
  logic [13:0] other_dout, other_oe_n, fabric_dout, fabric_oe_n, pad_din;
  logic [13:0] pad_dout, pad_oe_n, rx_data, output_drive_off_n;
  logic [13:0] slew_rate_fast, rx_enable, hysteresis_on;
  logic [13:0][1:0] pad_function_choice, out_src_sel, pull_mode;
  logic [13:0][1:0] drive_strength;
  int error_cnt = 0;
  int n_tests = 0;
  integer seed = 32'h82a7cbe2;
  logic [12:0] m [14];
  localparam logic [12:0] RST [14] = '{`PAD12_RST, `PAD13_RST, `PAD14_RST,
    `PAD15_RST, `PAD16_RST, `PAD17_RST, `PAD18_RST, `PAD19_RST, `PAD20_RST,
    `PAD21_RST, `PAD22_RST, `PAD23_RST, `PAD24_RST, `PAD25_RST};

  pad_config_bank #(.NPADS(14), .ADDR_W(12)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .func_dout(func_dout), .other_dout(other_dout),
    .other_oe_n(other_oe_n), .fabric_dout(fabric_dout),
    .fabric_oe_n(fabric_oe_n), .pad_din(pad_din),
    .pad_dout(pad_dout), .pad_oe_n(pad_oe_n), .rx_data(rx_data),
    .pad_function_choice(pad_function_choice), .out_src_sel(out_src_sel),
    .output_drive_off_n(output_drive_off_n), .pull_mode(pull_mode),
    .drive_strength(drive_strength), .slew_rate_fast(slew_rate_fast),
    .rx_enable(rx_enable), .hysteresis_on(hysteresis_on));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [11:0] adr(input int i);
    return `PAD12_SETUP_OFS + 12'(4 * i);
  endfunction

  // One edge first, so a strobe dropped by the last call is never
  // raised again in the same time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit ad, dd;
    int t;
    ad = 0;
    dd = 0;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd) && t < 40);
    do begin
      @(posedge aclk);
      t++;
    end while (bvalid !== 1'b1 && t < 80);
    chk(32'({bvalid, bresp}), 32'({1'b1, er}));
    bready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
    end while (arready !== 1'b1 && t < 40);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      t++;
    end while (rvalid !== 1'b1 && t < 80);
    chk(rdata, ed);
    chk(32'({rvalid, rresp}), 32'({1'b1, er}));
    rready <= 1'b0;
  endtask

  task automatic fchk(input int i);
    logic [31:0] f;
    f = 32'({hysteresis_on[i], rx_enable[i], slew_rate_fast[i],
      drive_strength[i], pull_mode[i], output_drive_off_n[i],
      out_src_sel[i], 1'b0, pad_function_choice[i]});
    chk(f, 32'(m[i]));
  endtask

  task automatic pchk;
    logic eo, ed;
    for (int i = 0; i < 14; i++) begin
      case (m[i][4:3])
        2'h0: begin
          eo = m[i][5];
          ed = func_dout[i][m[i][1:0]];
        end
        2'h1: begin
          eo = other_oe_n[i];
          ed = other_dout[i];
        end
        2'h2: begin
          eo = fabric_oe_n[i];
          ed = fabric_dout[i];
        end
        default: begin
          eo = 1'b1;
          ed = 1'b0;
        end
      endcase
      chk(32'({pad_oe_n[i], pad_dout[i]}), 32'({eo, ed}));
      chk(32'(rx_data[i]), 32'(pad_din[i] & m[i][11]));
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [3:0] s;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    func_dout = '0;
    {other_dout, other_oe_n, fabric_dout, fabric_oe_n, pad_din} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      m[i] = RST[i];
      rchk(adr(i), 32'(RST[i]), `RESP_OKAY);
      fchk(i);
    end
    $display("test reset values finished");
    // Rounds 0 to 3 force each source code; round 4 uses random strobes
    for (int r = 0; r < 5; r++) begin
      for (int i = 0; i < 14; i++) begin
        d = $random(seed);
        s = (r < 4) ? 4'hf : 4'($random(seed));
        if (r < 4)
          d[4:3] = 2'(r);
        wr(adr(i), d, s, `RESP_OKAY);
        if (s[0])
          m[i][7:0] = d[7:0];
        if (s[1])
          m[i][12:8] = d[12:8];
        m[i] = m[i] & `SETUP_MASK;
        fchk(i);
        rchk(adr(i), 32'(m[i]), `RESP_OKAY);
      end
      @(posedge aclk);
      for (int i = 0; i < 14; i++)
        func_dout[i] <= 4'($random(seed));
      other_dout <= 14'($random(seed));
      other_oe_n <= 14'($random(seed));
      fabric_dout <= 14'($random(seed));
      fabric_oe_n <= 14'($random(seed));
      pad_din <= 14'($random(seed));
      // Pin levels cross two sync flops plus the gating flop
      repeat (4) @(posedge aclk);
      pchk;
      $display("test write round %0d finished", r);
    end
    wr(12'h100, 32'hffffffff, 4'hf, `RESP_SLVERR);
    wr(12'h035, 32'hffffffff, 4'hf, `RESP_SLVERR);
    wr(12'h02c, 32'hffffffff, 4'hf, `RESP_SLVERR);
    rchk(12'h100, 32'h0, `RESP_SLVERR);
    rchk(12'h068, 32'h0, `RESP_SLVERR);
    for (int i = 0; i < 14; i++) begin
      fchk(i);
      rchk(adr(i), 32'(m[i]), `RESP_OKAY);
    end
    $display("test unmapped access finished");
    // Mid-run reset with random source and pin levels still applied
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(pad_oe_n), 32'(14'h3fff));
    chk(32'({pad_dout, rx_data}), 32'h0);
    aresetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      m[i] = RST[i];
      fchk(i);
      rchk(adr(i), 32'(m[i]), `RESP_OKAY);
    end
    $display("test mid-run reset finished");
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run;
  end
endmodule
